/* core/tbpwm_channel.sv */
`timescale 1ns/1ns
// Contract
// - pulse generator runs only while control bit 7 is set
// - control bit 4 selects polarity; 1 inverts the waveform
// - duty-high register holds duty bits 9..2
// - duty-low bits 7..6 hold duty bits 1..0, left-justified
// - unimplemented control and duty-low bits read zero, writes ignored
// - enable and polarity clear on any reset; duty kept through soft reset
// - disabled channel drives idle level: equal to polarity bit
// - on period match: clear timer, go active unless duty zero, latch duty
// - duty is double-buffered; new value used only from the period match
// - ten-bit time base is timer count plus two prescaler or clock-phase bits
module tbpwm_channel (
  input  wire logic                    ref_clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    soft_rst_i,
  input  wire tbpwm_pkg::tbpwm_av_req_t av_i,
  output logic [tbpwm_pkg::DW-1:0]     av_readdata_o,
  output logic                         av_waitrequest_o,
  output logic                         pwm_o
);
  import tbpwm_pkg::*;

  tbpwm_state_t      st;
  tbpwm_state_t      next_st;
  logic              req;
  logic              tick;
  logic              match;
  logic [DUTY_W-1:0] tb;

  function automatic logic [PC_W-1:0] pc_last(input logic [1:0] psel);
    case (psel)
      PSC_1:   pc_last = PC_LAST_1;
      PSC_4:   pc_last = PC_LAST_4;
      default: pc_last = PC_LAST_16;
    endcase
  endfunction

  // the two low time-base bits are the top two bits of the prescale count
  function automatic logic [1:0] tb_low(input logic [1:0] psel, input logic [PC_W-1:0] pc);
    case (psel)
      PSC_1:   tb_low = pc[1:0];
      PSC_4:   tb_low = pc[3:2];
      default: tb_low = pc[5:4];
    endcase
  endfunction

  assign req              = av_i.read | av_i.write;
  assign tb               = {st.tmr, tb_low(st.psel, st.pc)};
  assign av_waitrequest_o = req & ~st.ack;
  assign av_readdata_o    = st.rdata;
  assign pwm_o            = st.pin;

  always_comb begin
    next_st = st;
    tick    = 1'b0;
    match   = 1'b0;
    // time base advances once per clock at 1:1, else once per prescale step
    if (st.tmr_on) begin
      if (st.pc == pc_last(st.psel)) begin
        next_st.pc = '0;
        tick       = 1'b1;
      end else begin
        next_st.pc = st.pc + 6'h01;
      end
    end
    match = tick && (st.tmr == st.pr);
    if (match) begin
      next_st.tmr    = '0;
      next_st.dc_lat = st.dc_buf;
      next_st.active = st.en && (st.dc_buf != '0);
    end else begin
      if (tick) begin
        next_st.tmr = st.tmr + 8'h01;
      end
      // equality, not compare: a duty beyond the period is never reached
      // compare the time base of the next cycle so the pulse spans exactly duty steps
      if ({next_st.tmr, tb_low(st.psel, next_st.pc)} == st.dc_lat) begin
        next_st.active = 1'b0;
      end
    end
    if (!st.en) begin
      next_st.active = 1'b0;
    end
    next_st.pin = st.en ? (st.active ^ st.pol) : st.pol;

    // one wait state: read data is captured on the first edge of a request
    next_st.ack = req && !st.ack;
    if (req && !st.ack) begin
      next_st.rdata = RDATA_ZERO;
      if (av_i.read) begin
        case (av_i.address)
          CHANNEL_CONTROL_REG: begin
            next_st.rdata[CTRL_EN_BIT]  = st.en;
            next_st.rdata[CTRL_OUT_BIT] = st.pin;
            next_st.rdata[CTRL_POL_BIT] = st.pol;
          end
          DUTY_HIGH_REG:    next_st.rdata[7:0] = st.dc_buf[9:2];
          DUTY_LOW_REG:     next_st.rdata[7:DCL_LSB_POS] = st.dc_buf[1:0];
          PERIOD_LIMIT_REG: next_st.rdata[7:0] = st.pr;
          TIMER_CONFIG_REG: begin
            next_st.rdata[TCFG_ON_BIT] = st.tmr_on;
            next_st.rdata[1:0]         = st.psel;
          end
          TIMER_COUNT_REG:  next_st.rdata[7:0] = st.tmr;
          default:          next_st.rdata = RDATA_ZERO;
        endcase
      end
    end
    if (av_i.write && st.ack && av_i.byteenable[0]) begin
      case (av_i.address)
        CHANNEL_CONTROL_REG: begin
          next_st.en  = av_i.writedata[CTRL_EN_BIT];
          next_st.pol = av_i.writedata[CTRL_POL_BIT];
        end
        DUTY_HIGH_REG:    next_st.dc_buf[9:2] = av_i.writedata[7:0];
        DUTY_LOW_REG:     next_st.dc_buf[1:0] = av_i.writedata[7:DCL_LSB_POS];
        PERIOD_LIMIT_REG: next_st.pr = av_i.writedata[7:0];
        TIMER_CONFIG_REG: begin
          next_st.tmr_on = av_i.writedata[TCFG_ON_BIT];
          next_st.psel   = av_i.writedata[1:0];
        end
        default: ;
      endcase
    end
    // soft reset clears control but keeps the duty value
    if (soft_rst_i) begin
      next_st.en     = 1'b0;
      next_st.pol    = 1'b0;
      next_st.active = 1'b0;
    end
  end

  // power-on reset: duty is unknown there, zero is chosen so it is defined
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_match;
    tick && (st.tmr == st.pr);
  endsequence

  sequence s_after_match(logic [DUTY_W-1:0] d, logic e);
    (st.tmr == '0) && (st.dc_lat == d) && (st.active == (e && d != '0));
  endsequence

  property p_disabled_quiet;
    !st.en |=> !st.active;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("active while disabled");

  property p_readback;
    (av_i.read && !st.ack && av_i.address == CHANNEL_CONTROL_REG)
      |=> av_readdata_o[CTRL_OUT_BIT] == $past(pwm_o) && !av_waitrequest_o;
  endproperty
  a_readback: assert property (p_readback) else $error("level readback wrong");

  property p_polarity;
    $past(st.en) |-> pwm_o == ($past(st.active) ^ $past(st.pol));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");

  property p_duty_high;
    (av_i.write && st.ack && av_i.byteenable[0] && av_i.address == DUTY_HIGH_REG && !match)
      |=> st.dc_buf[9:2] == $past(av_i.writedata[7:0]);
  endproperty
  a_duty_high: assert property (p_duty_high) else $error("duty high not stored");

  property p_duty_low;
    (av_i.write && st.ack && av_i.byteenable[0] && av_i.address == DUTY_LOW_REG)
      |=> st.dc_buf[1:0] == $past(av_i.writedata[7:6]) && $stable(st.dc_buf[9:2]);
  endproperty
  a_duty_low: assert property (p_duty_low) else $error("duty low not stored");

  property p_unimpl_zero;
    (st.ack && av_i.read && av_i.address == DUTY_LOW_REG)
      |-> av_readdata_o[5:0] == '0 && av_readdata_o[31:8] == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits set");

  property p_soft_reset;
    soft_rst_i |=> !st.en && !st.pol && st.dc_buf == $past(st.dc_buf);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

  property p_idle_level;
    $past(!st.en) |-> pwm_o == $past(st.pol);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

  property p_period_match;
    logic [DUTY_W-1:0] d;
    logic e;
    (s_match, d = st.dc_buf, e = st.en) ##1 !$past(soft_rst_i) |-> s_after_match(d, e);
  endproperty
  a_period_match: assert property (p_period_match) else $error("period match wrong");

  property p_buffered;
    !match |=> st.dc_lat == $past(st.dc_lat);
  endproperty
  a_buffered: assert property (p_buffered) else $error("duty latched off match");

  property p_timer_hold;
    !tick |=> st.tmr == $past(st.tmr);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer moved off tick");

  property p_pulse_end;
    (tb == st.dc_lat && !match && st.tmr_on) |=> !st.active;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");

endmodule

/* core/tbpwm_pkg.sv */
package tbpwm_pkg;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned DUTY_W = 10;
  localparam int unsigned TMR_W = 8;
  localparam int unsigned PC_W = 6;

  // register byte addresses, one aligned word each
  localparam logic [AW-1:0] CHANNEL_CONTROL_REG = 8'h00;
  localparam logic [AW-1:0] DUTY_HIGH_REG       = 8'h04;
  localparam logic [AW-1:0] DUTY_LOW_REG        = 8'h08;
  localparam logic [AW-1:0] PERIOD_LIMIT_REG    = 8'h0C;
  localparam logic [AW-1:0] TIMER_CONFIG_REG    = 8'h10;
  localparam logic [AW-1:0] TIMER_COUNT_REG     = 8'h14;

  // field positions
  localparam int unsigned CTRL_EN_BIT  = 7;
  localparam int unsigned CTRL_OUT_BIT = 5;
  localparam int unsigned CTRL_POL_BIT = 4;
  localparam int unsigned DCL_LSB_POS  = 6;
  localparam int unsigned TCFG_ON_BIT  = 2;

  // prescale select codes
  localparam logic [1:0] PSC_1  = 2'h0;
  localparam logic [1:0] PSC_4  = 2'h1;

  // last prescale count: 4 * prescale - 1
  localparam logic [PC_W-1:0] PC_LAST_1  = 6'h03;
  localparam logic [PC_W-1:0] PC_LAST_4  = 6'h0F;
  localparam logic [PC_W-1:0] PC_LAST_16 = 6'h3F;

  localparam logic [DW-1:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
    logic [3:0]    byteenable;
  } tbpwm_av_req_t;

  typedef struct packed {
    logic              en;
    logic              pol;
    logic              pin;
    logic              active;
    logic [DUTY_W-1:0] dc_buf;
    logic [DUTY_W-1:0] dc_lat;
    logic [TMR_W-1:0]  pr;
    logic              tmr_on;
    logic [1:0]        psel;
    logic [TMR_W-1:0]  tmr;
    logic [PC_W-1:0]   pc;
    logic              ack;
    logic [DW-1:0]     rdata;
  } tbpwm_state_t;

endpackage

/* dv/tbpwm_load.sv */
`timescale 1ns/1ns
// load on the pwm pin: counts clocks the pin is high since the last clear
// a window that spans whole periods gives an exact count whatever the phase
module tbpwm_load (
  input  wire logic        ref_clk_i,
  input  wire logic        clr_i,
  input  wire logic        pin_i,
  output logic [15:0]      high_cnt_o
);
  always_ff @(posedge ref_clk_i) begin
    if (clr_i) begin
      high_cnt_o <= 16'h0000;
    end else if (pin_i) begin
      high_cnt_o <= high_cnt_o + 16'h0001;
    end
  end
endmodule

/* dv/tbpwm_channel_tb_top.sv */
`timescale 1ns/1ns
module tbpwm_channel_tb_top;
  import tbpwm_pkg::*;
  logic                clk = 1'b0;
  logic                arst_n;
  logic                soft_rst;
  logic                clr;
  tbpwm_av_req_t       av;
  logic [DW-1:0]       rdata;
  logic                wait_req;
  logic                pwm;
  logic [15:0]         high_cnt;
  logic [DW-1:0]       rv;
  int                  errors = 0;
  int                  total_checks = 0;
  int                  cycles = 0;

  always #10 clk = ~clk;

  tbpwm_channel dut (
    .ref_clk_i        (clk),
    .arst_n_i         (arst_n),
    .soft_rst_i       (soft_rst),
    .av_i             (av),
    .av_readdata_o    (rdata),
    .av_waitrequest_o (wait_req),
    .pwm_o            (pwm)
  );

  tbpwm_load load (
    .ref_clk_i  (clk),
    .clr_i      (clr),
    .pin_i      (pwm),
    .high_cnt_o (high_cnt)
  );

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // called just after a rising edge; one idle edge after each transfer
  // keeps the release and the next request out of the same time step
  task automatic xfer(input logic rd, input logic [AW-1:0] a, input logic [7:0] d);
    av.read <= rd;
    av.write <= ~rd;
    av.address <= a;
    av.writedata <= {24'h000000, d};
    av.byteenable <= 4'hF;
    do @(posedge clk); while (wait_req !== 1'b0);
    rv = rdata;
    av.read <= 1'b0;
    av.write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask

  task automatic rd_chk(input string n, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    xfer(1'b1, a, 8'h00);
    chk(n, exp, rv);
  endtask

  // settle for one window, then count high clocks over a window
  task automatic meas(input string n, input int w, input logic [15:0] exp);
    repeat (w) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
    chk(n, {16'h0000, exp}, {16'h0000, high_cnt});
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    arst_n = 1'b0;
    soft_rst = 1'b0;
    clr = 1'b0;
    av = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk("control after reset", CHANNEL_CONTROL_REG, 32'h00000000);
    wr(CHANNEL_CONTROL_REG, 8'hFF);
    rd_chk("control all ones", CHANNEL_CONTROL_REG, 32'h000000B0);
    wr(DUTY_LOW_REG, 8'hFF);
    rd_chk("duty low", DUTY_LOW_REG, 32'h000000C0);
    wr(DUTY_HIGH_REG, 8'hA5);
    rd_chk("duty high", DUTY_HIGH_REG, 32'h000000A5);
    rd_chk("unmapped", 8'h20, RDATA_ZERO);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    @(posedge clk);
    rd_chk("control after soft reset", CHANNEL_CONTROL_REG, 32'h00000000);
    rd_chk("duty high kept", DUTY_HIGH_REG, 32'h000000A5);
    rd_chk("duty low kept", DUTY_LOW_REG, 32'h000000C0);
    // period 16 clocks, duty 6
    wr(PERIOD_LIMIT_REG, 8'h03);
    wr(DUTY_HIGH_REG, 8'h01);
    wr(DUTY_LOW_REG, 8'h80);
    wr(TIMER_CONFIG_REG, 8'h04);
    meas("idle low", 64, 16'h0000);
    wr(CHANNEL_CONTROL_REG, 8'h10);
    meas("idle high", 64, 16'h0040);
    wr(CHANNEL_CONTROL_REG, 8'h80);
    meas("duty six", 64, 16'h0018);
    wr(CHANNEL_CONTROL_REG, 8'h90);
    meas("inverted", 64, 16'h0028);
    wr(CHANNEL_CONTROL_REG, 8'h80);
    wr(DUTY_HIGH_REG, 8'h00);
    wr(DUTY_LOW_REG, 8'h00);
    meas("duty zero", 64, 16'h0000);
    wr(DUTY_HIGH_REG, 8'hFF);
    wr(DUTY_LOW_REG, 8'hC0);
    meas("duty above period", 64, 16'h0040);
    wr(DUTY_HIGH_REG, 8'h01);
    wr(DUTY_LOW_REG, 8'h80);
    wr(TIMER_CONFIG_REG, 8'h05);
    meas("prescale four", 128, 16'h0030);
    wrap_up();
  end
endmodule
